/* File: logic/sbs_pkg.sv */
// shared constants and types for the burst sram model
// assumes one clock and a bus master working on that same clock
package sbs_pkg;
  localparam int ADDR_W     = 17;
  localparam int DATA_W     = 36;
  localparam int LANES      = 4;
  localparam int LANE_W     = 9;
  localparam int MEM_AW     = 6;
  localparam int MEM_DEPTH  = 64;
  localparam int FIFO_DEPTH = 8;
  localparam int BURST_LEN  = 4;
  localparam logic [LANES-1:0] LANES_ALL  = 4'hF;
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;
  localparam logic [1:0]       CNT_FIRST  = 2'h0;
  localparam logic [1:0]       CNT_STEP   = 2'h1;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_BURST = 2'b01,
    ST_SLEEP = 2'b10
  } sbs_state_type;
endpackage

/* File: logic/sbs_burst_order.sv */
// low address bits of a burst word from start value and count
// assumes a static order select, already synchronised
`timescale 1ns/10ps
module sbs_burst_order (
  input  wire logic       interleaved,
  input  wire logic [1:0] base,
  input  wire logic [1:0] count,
  output logic      [1:0] lowAddr
);
  // linear wraps by dropping the carry, interleaved flips bits
  always_comb begin
    if (interleaved) begin
      lowAddr = base ^ count;
    end else begin
      lowAddr = 2'(base + count);
    end
  end
endmodule

/* File: logic/sbs_fifo.sv */
// first-in first-out buffer held in flip-flops
// assumes both sides on clk; pop and push may share a cycle
`timescale 1ns/10ps
module sbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] slotFf [DEPTH];
  logic [PW-1:0]    wrPtrFf;
  logic [PW-1:0]    rdPtrFf;
  logic [PW:0]      countFf;
  logic             push;
  logic             pop;

  // honest full and empty straight from the occupancy count
  assign inReady  = (countFf != (PW+1)'(DEPTH));
  assign outValid = (countFf != '0);
  assign outData  = slotFf[rdPtrFf];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // pointers wrap because the depth is a power of two
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtrFf <= '0;
      rdPtrFf <= '0;
      countFf <= '0;
    end else begin
      if (push) begin
        wrPtrFf <= PW'(wrPtrFf + 1'b1);
      end
      if (pop) begin
        rdPtrFf <= PW'(rdPtrFf + 1'b1);
      end
      if (push && !pop) begin
        countFf <= (PW+1)'(countFf + 1'b1);
      end else if (pop && !push) begin
        countFf <= (PW+1)'(countFf - 1'b1);
      end
    end
  end

  // storage needs no reset, the count guards it
  always_ff @(posedge clk) begin
    if (push) begin
      slotFf[wrPtrFf] <= inData;
    end
  end
endmodule

/* File: logic/sbs_sram.sv */
// pipelined synchronous burst sram with four word burst counter
// assumes the master drives all pins from the same clock edge
`timescale 1ns/10ps
module sbs_sram (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic [sbs_pkg::ADDR_W-1:0]  addrIn,
  input  wire logic                        chipEnableN,
  input  wire logic                        selectHigh,
  input  wire logic                        selectLowN,
  input  wire logic                        processorAddrStrobeN,
  input  wire logic                        controllerAddrStrobeN,
  input  wire logic                        burstStepN,
  input  wire logic                        globalWriteN,
  input  wire logic                        byteWriteEnableN,
  input  wire logic [sbs_pkg::LANES-1:0]   byteLaneWriteN,
  input  wire logic                        outputEnableN,
  input  wire logic                        sleepRequest,
  input  wire logic                        burstOrderSelectN,
  input  wire logic [sbs_pkg::DATA_W-1:0]  dqIn,
  output logic      [sbs_pkg::DATA_W-1:0]  dqOut,
  output logic                             dqOe,
  output logic                             writeReady
);
  import sbs_pkg::*;

  localparam int FW = MEM_AW + LANES + DATA_W;

  sbs_state_type     stateFf;
  sbs_state_type     nxt_state;
  logic [ADDR_W-1:0] addrFf;
  logic [ADDR_W-1:0] curAddr;
  logic [1:0]        baseFf;
  logic [1:0]        cntFf;
  logic [1:0]        nxt_cnt;
  logic [1:0]        stepLow;
  logic              strapMetaFf;
  logic              strapFf;
  logic              rdPendFf;
  logic              rdValidFf;
  logic [DATA_W-1:0] rdDataFf;
  logic [DATA_W-1:0] memFf [MEM_DEPTH];
  logic              selected;
  logic              anyStrobe;
  logic              procStart;
  logic              ctrlStart;
  logic              startGo;
  logic              contCyc;
  logic              advance;
  logic              deselect;
  logic [LANES-1:0]  wrLanes;
  logic              readGo;
  logic              writeGo;
  logic              fifoInReady;
  logic              headValid;
  logic [FW-1:0]     headWord;
  logic [MEM_AW-1:0] headIdx;
  logic [LANES-1:0]  headLanes;
  logic [DATA_W-1:0] headData;
  logic              drainGo;
  logic [DATA_W-1:0] memWord;

  // lanes written by the write controls of one cycle
  function automatic logic [LANES-1:0] laneDecode(
    input logic             gwN,
    input logic             bweN,
    input logic [LANES-1:0] laneN
  );
    logic [LANES-1:0] res;
    res = LANES_NONE;
    if (!gwN) begin
      res = LANES_ALL;
    end else if (!bweN) begin
      res = ~laneN;
    end
    return res;
  endfunction

  // overlay the enabled lanes of a new word on an old one
  function automatic logic [DATA_W-1:0] laneMerge(
    input logic [DATA_W-1:0] oldW,
    input logic [DATA_W-1:0] newW,
    input logic [LANES-1:0]  lanes
  );
    logic [DATA_W-1:0] res;
    res = oldW;
    for (int i = 0; i < LANES; i++) begin
      if (lanes[i]) begin
        res[i*LANE_W +: LANE_W] = newW[i*LANE_W +: LANE_W];
      end
    end
    return res;
  endfunction

  // strap is static but asynchronous to clk, so it is synchronised
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strapMetaFf <= 1'b0;
      strapFf     <= 1'b0;
    end else begin
      strapMetaFf <= burstOrderSelectN;
      strapFf     <= strapMetaFf;
    end
  end

  // cycle decode; processor strobe starts a read when selected and awake, whatever the write pins
  assign selected  = !chipEnableN && selectHigh && !selectLowN;
  assign anyStrobe = !processorAddrStrobeN || !controllerAddrStrobeN;
  assign procStart = !processorAddrStrobeN && selected;
  assign ctrlStart = processorAddrStrobeN && !controllerAddrStrobeN
                     && selected;
  assign startGo   = (procStart || ctrlStart) && !sleepRequest;
  assign deselect  = anyStrobe && !selected;
  assign contCyc   = !anyStrobe && (stateFf == ST_BURST) && !sleepRequest;
  assign advance   = contCyc && !burstStepN;
  assign wrLanes   = laneDecode(globalWriteN, byteWriteEnableN,
                                byteLaneWriteN);
  assign readGo    = procStart && !sleepRequest
                     || (ctrlStart && !sleepRequest || contCyc)
                        && (wrLanes == LANES_NONE);
  // a full buffer refuses the write; writeReady reports this at the pins
  assign writeGo   = (ctrlStart && !sleepRequest || contCyc)
                     && (wrLanes != LANES_NONE) && fifoInReady;

  // next word of the sequence, counted from the start value
  assign nxt_cnt = 2'(cntFf + CNT_STEP);
  sbs_burst_order u_order (
    .interleaved (strapFf),
    .base        (baseFf),
    .count       (nxt_cnt),
    .lowAddr     (stepLow)
  );

  // upper bits stay put; a held step reuses the address
  always_comb begin
    if (startGo) begin
      curAddr = addrIn;
    end else if (advance) begin
      curAddr = {addrFf[ADDR_W-1:2], stepLow};
    end else begin
      curAddr = addrFf;
    end
  end

  // burst state: sleep drops any burst in flight
  always_comb begin
    case (stateFf)
      ST_IDLE: begin
        nxt_state = startGo ? ST_BURST : ST_IDLE;
      end
      ST_BURST: begin
        nxt_state = deselect ? ST_IDLE : ST_BURST;
      end
      ST_SLEEP: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (sleepRequest) begin
      nxt_state = ST_SLEEP;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stateFf <= ST_IDLE;
    end else begin
      stateFf <= nxt_state;
    end
  end

  // address register, start value and burst counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addrFf <= '0;
      baseFf <= CNT_FIRST;
      cntFf  <= CNT_FIRST;
    end else if (startGo) begin
      addrFf <= addrIn;
      baseFf <= addrIn[1:0];
      cntFf  <= CNT_FIRST;
    end else if (advance) begin
      addrFf <= curAddr;
      cntFf  <= nxt_cnt;
    end
  end

  // writes queue up, then retire into the array one per clock
  sbs_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_wrfifo (
    .clk      (clk),
    .rst      (rst),
    .inValid  (writeGo),
    .inReady  (fifoInReady),
    .inData   ({curAddr[MEM_AW-1:0], wrLanes, dqIn}),
    .outValid (headValid),
    .outReady (!sleepRequest),
    .outData  (headWord)
  );

  assign headIdx   = headWord[FW-1 -: MEM_AW];
  assign headLanes = headWord[DATA_W +: LANES];
  assign headData  = headWord[DATA_W-1:0];
  // array is frozen in sleep, so the buffer holds pending writes
  assign drainGo   = headValid && !sleepRequest;

  always_ff @(posedge clk) begin
    if (drainGo) begin
      memFf[headIdx] <= laneMerge(memFf[headIdx], headData, headLanes);
    end
  end

  // awake, at most one write waits, so forwarding the head suffices
  always_comb begin
    memWord = memFf[addrFf[MEM_AW-1:0]];
    if (headValid && headIdx == addrFf[MEM_AW-1:0]) begin
      memWord = laneMerge(memWord, headData, headLanes);
    end
  end

  // one stage between the registered address and the data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdPendFf  <= 1'b0;
      rdValidFf <= 1'b0;
      rdDataFf  <= '0;
    end else begin
      rdPendFf  <= readGo;
      rdValidFf <= rdPendFf && !sleepRequest;
      if (rdPendFf) begin
        rdDataFf <= memWord;
      end
    end
  end

  assign dqOut      = rdDataFf;
  assign writeReady = fifoInReady;
  // enable is a pin-level gate, deliberately not clocked
  assign dqOe = rdValidFf && !outputEnableN && !sleepRequest;

  // checks

  sequence s_step;
    advance && !startGo;
  endsequence

  sequence s_four_steps;
    s_step [*4];
  endsequence

  property p_linear_step;
    @(posedge clk) disable iff (rst)
    (s_step and !strapFf) |=> addrFf[1:0] == 2'($past(addrFf[1:0]) + 2'h1);
  endproperty
  a_linear_step: assert property (p_linear_step)
    else $error("linear burst did not count up by one");

  property p_wrap;
    @(posedge clk) disable iff (rst)
    s_four_steps |=> addrFf[1:0] == $past(addrFf[1:0], 4);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("burst did not return to its start after four words");

  property p_upper_fixed;
    @(posedge clk) disable iff (rst)
    contCyc |=> addrFf[ADDR_W-1:2] == $past(addrFf[ADDR_W-1:2]);
  endproperty
  a_upper_fixed: assert property (p_upper_fixed)
    else $error("upper address bits moved during a burst");

  property p_hold;
    @(posedge clk) disable iff (rst)
    contCyc && burstStepN |=> $stable(addrFf) && $stable(cntFf);
  endproperty
  a_hold: assert property (p_hold)
    else $error("held burst changed its address");

  property p_base_first;
    @(posedge clk) disable iff (rst)
    startGo |=> addrFf == $past(addrIn) && cntFf == CNT_FIRST;
  endproperty
  a_base_first: assert property (p_base_first)
    else $error("burst did not start at the external address");

  property p_write_target;
    @(posedge clk) disable iff (rst)
    writeGo && contCyc |=> headValid && headIdx == addrFf[MEM_AW-1:0]
                           && headData == $past(dqIn);
  endproperty
  a_write_target: assert property (p_write_target)
    else $error("burst write went to another address");

  property p_interleave;
    @(posedge clk) disable iff (rst)
    stateFf == ST_BURST && strapFf && $stable(strapFf)
      |-> addrFf[1:0] == (baseFf ^ cntFf);
  endproperty
  a_interleave: assert property (p_interleave)
    else $error("interleaved address is not start xor count");

  property p_oe_gate;
    @(posedge clk) disable iff (rst)
    outputEnableN || !rdValidFf |-> !dqOe;
  endproperty
  a_oe_gate: assert property (p_oe_gate)
    else $error("data driven while output enable was high");

  property p_byte_lanes;
    @(posedge clk) disable iff (rst)
    globalWriteN && !byteWriteEnableN && writeGo
      |=> headValid && headLanes == ~$past(byteLaneWriteN);
  endproperty
  a_byte_lanes: assert property (p_byte_lanes)
    else $error("byte lane write set the wrong lanes");

  sequence s_read_issue;
    readGo && !sleepRequest;
  endsequence

  property p_read_latency;
    @(posedge clk) disable iff (rst)
    s_read_issue ##1 !sleepRequest |=> rdValidFf;
  endproperty
  a_read_latency: assert property (p_read_latency)
    else $error("read data not valid one edge after the address");

  property p_global_write;
    @(posedge clk) disable iff (rst)
    !globalWriteN && writeGo |=> headValid && headLanes == LANES_ALL;
  endproperty
  a_global_write: assert property (p_global_write)
    else $error("global write did not enable every lane");
endmodule

/* File: tb/sbs_bus_master.sv */
// bus master model that drives every control and data pin of the sram
// assumes the bench calls its tasks from one process, all on clk
`timescale 1ns/10ps
module sbs_bus_master (
  input  wire logic                       clk,
  output logic      [sbs_pkg::ADDR_W-1:0] addrIn,
  output logic                            chipEnableN,
  output logic                            selectHigh,
  output logic                            selectLowN,
  output logic                            processorAddrStrobeN,
  output logic                            controllerAddrStrobeN,
  output logic                            burstStepN,
  output logic                            globalWriteN,
  output logic                            byteWriteEnableN,
  output logic      [sbs_pkg::LANES-1:0]  byteLaneWriteN,
  output logic                            outputEnableN,
  output logic                            sleepRequest,
  output logic                            burstOrderSelectN,
  output logic      [sbs_pkg::DATA_W-1:0] dqIn
);
  import sbs_pkg::*;
  // pins at rest: deselected, strobes high, awake, linear order
  initial begin
    addrIn = '0;
    chipEnableN = 1'b1;
    selectHigh = 1'b0;
    selectLowN = 1'b1;
    processorAddrStrobeN = 1'b1;
    controllerAddrStrobeN = 1'b1;
    burstStepN = 1'b1;
    globalWriteN = 1'b1;
    byteWriteEnableN = 1'b1;
    byteLaneWriteN = 4'hF;
    outputEnableN = 1'b0;
    sleepRequest = 1'b0;
    burstOrderSelectN = 1'b0;
    dqIn = '0;
  end

  // one bus cycle; kind 0 continue, 1 controller start, 2 processor start,
  // 3 controller strobe while deselected, which closes the burst
  task automatic cyc(input int kind, input logic [ADDR_W-1:0] a,
                     input logic stepN, input logic gwN, input logic bweN,
                     input logic [LANES-1:0] lanesN,
                     input logic [DATA_W-1:0] d);
    logic wr;
    wr = (kind != 2) && (!gwN || (!bweN && lanesN != LANES_ALL));
    @(posedge clk);
    chipEnableN <= (kind == 0 || kind == 3);
    selectLowN <= (kind == 0 || kind == 3);
    selectHigh <= (kind == 1 || kind == 2);
    processorAddrStrobeN <= (kind != 2);
    controllerAddrStrobeN <= (kind != 1 && kind != 3);
    addrIn <= a;
    burstStepN <= stepN;
    globalWriteN <= gwN;
    byteWriteEnableN <= bweN;
    byteLaneWriteN <= lanesN;
    // caller repeats the word on a held write
    // idle data is inverted so a stale word can never pass as written
    dqIn <= wr ? d : ~dqIn;
  endtask

  // strap is only touched while reset holds the device
  task automatic set_strap(input logic v);
    @(posedge clk);
    burstOrderSelectN <= v;
  endtask

  task automatic set_oe(input logic v);
    @(posedge clk);
    outputEnableN <= v;
  endtask

  // sleep is raised here right after a read start, with the burst still open
  // pins go to rest with it, so no start is left standing at wake
  task automatic sleep_on();
    @(posedge clk);
    sleepRequest <= 1'b1;
    chipEnableN <= 1'b1;
    selectHigh <= 1'b0;
    selectLowN <= 1'b1;
    processorAddrStrobeN <= 1'b1;
    controllerAddrStrobeN <= 1'b1;
    burstStepN <= 1'b1;
    globalWriteN <= 1'b1;
    byteWriteEnableN <= 1'b1;
  endtask

  // 120 ns of sleep, then 3 deselected clocks of recovery
  task automatic wake();
    repeat (3) @(posedge clk);
    sleepRequest <= 1'b0;
    repeat (3) cyc(0, '0, 1'b1, 1'b1, 1'b1, LANES_ALL, '0);
  endtask
endmodule

/* File: tb/sbs_tb.sv */
// self-checking bench for the burst sram, driven through a master model
// assumes the 25 MHz clock and reads visible two edges after the start
`timescale 1ns/10ps
module tb;
  import sbs_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] addrIn;
  logic              ceN, selHi, selLoN, procN, ctrlN, stepN, gwN, bweN;
  logic [LANES-1:0]  lanesN;
  logic              oeN, sleep, orderN, dqOe, writeReady;
  logic [DATA_W-1:0] dqIn, dqOut;
  logic [DATA_W-1:0] expMem [MEM_DEPTH];
  logic              inter = 1'b0;
  int                failures = 0;
  int                num_checks = 0;

  always #20 clk = ~clk;

  sbs_bus_master m (.clk(clk), .addrIn(addrIn), .chipEnableN(ceN),
    .selectHigh(selHi), .selectLowN(selLoN), .processorAddrStrobeN(procN),
    .controllerAddrStrobeN(ctrlN), .burstStepN(stepN), .globalWriteN(gwN),
    .byteWriteEnableN(bweN), .byteLaneWriteN(lanesN), .outputEnableN(oeN),
    .sleepRequest(sleep), .burstOrderSelectN(orderN), .dqIn(dqIn));

  sbs_sram dut (.clk(clk), .rst(rst), .addrIn(addrIn), .chipEnableN(ceN),
    .selectHigh(selHi), .selectLowN(selLoN), .processorAddrStrobeN(procN),
    .controllerAddrStrobeN(ctrlN), .burstStepN(stepN), .globalWriteN(gwN),
    .byteWriteEnableN(bweN), .byteLaneWriteN(lanesN), .outputEnableN(oeN),
    .sleepRequest(sleep), .burstOrderSelectN(orderN), .dqIn(dqIn),
    .dqOut(dqOut), .dqOe(dqOe), .writeReady(writeReady));

  task automatic check_word(input string what, input logic [DATA_W-1:0] e,
                            input logic [DATA_W-1:0] s);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic check_bit(input string what, input logic e, input logic s);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %b seen %b", what, e, s);
    end
  endtask

  // word index of the n-th burst step from base a
  function automatic logic [MEM_AW-1:0] word_at(input logic [ADDR_W-1:0] a,
                                                input int n);
    logic [1:0] lo;
    lo = inter ? (a[1:0] ^ 2'(n)) : (a[1:0] + 2'(n));
    return {a[5:2], lo};
  endfunction

  // write burst of len cycles after the start, holding at step holdAt (0 = no hold)
  task automatic wr_burst(input logic [ADDR_W-1:0] a, input int len,
                          input int holdAt, input logic g, input logic b,
                          input logic [LANES-1:0] ln);
    int                cnt;
    logic [DATA_W-1:0] d;
    cnt = 0;
    for (int j = 0; j <= len; j++) begin
      if (j > 0 && j != holdAt) cnt++;
      d = {a[7:0], 20'h5C30F, 8'(cnt)};
      m.cyc(j == 0 ? 1 : 0, a, j == holdAt, g, b, ln, d);
      for (int l = 0; l < LANES; l++) begin
        if (!g || (!b && !ln[l])) begin
          expMem[word_at(a, cnt)][l*LANE_W +: LANE_W] = d[l*LANE_W +: LANE_W];
        end
      end
    end
  endtask

  // read burst; the word from each cycle shows two edges after it
  task automatic rd_burst(input logic [ADDR_W-1:0] a, input int len,
                          input int holdAt, input int kind);
    int   cnt;
    logic pa;
    logic burst_step_n;
    cnt = 0;
    pa = 1'b0;
    m.cyc(kind, a, 1'b1, 1'b1, 1'b1, LANES_ALL, '0);
    for (int j = 1; j <= len + 1; j++) begin
      burst_step_n = (j <= len) && (j != holdAt);
      m.cyc(0, a, !burst_step_n, 1'b1, 1'b1, LANES_ALL, '0);
      #1;
      if (j >= 2) begin
        check_word("dqOut", expMem[word_at(a, cnt)], dqOut);
        check_bit("dqOe", 1'b1, dqOe);
      end
      cnt += int'(pa);
      pa = burst_step_n;
    end
  endtask

  // strap only moves under reset, then 3 edges for its synchroniser
  task automatic do_reset(input logic strap);
    m.set_strap(strap);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1;
    check_bit("dqOe", 1'b0, dqOe);
    check_word("dqOut", '0, dqOut);
    check_bit("writeReady", 1'b1, writeReady);
    repeat (3) @(posedge clk);
  endtask

  // linear order, wrap on the fifth word, upper bits ignored by step
  task automatic t_linear();
    wr_burst(17'h10005, 3, 0, 1'b0, 1'b1, 4'hF);
    rd_burst(17'h10005, 5, 0, 2);
    rd_burst(17'h00007, 5, 0, 1);
  endtask

  // suspended write keeps its word, suspended read repeats it
  task automatic t_suspend();
    wr_burst(17'h00009, 4, 2, 1'b1, 1'b0, 4'h0);
    rd_burst(17'h00009, 5, 3, 2);
  endtask

  // lane strobes, all-lane global write, and a lane-less no-op
  task automatic t_lanes();
    wr_burst(17'h00011, 0, 0, 1'b0, 1'b1, 4'h0);
    wr_burst(17'h00051, 0, 0, 1'b1, 1'b0, 4'hA);
    wr_burst(17'h00091, 0, 0, 1'b1, 1'b0, 4'h5);
    wr_burst(17'h000D1, 0, 0, 1'b1, 1'b0, 4'hF);
    rd_burst(17'h00011, 1, 0, 1);
  endtask

  // sleep hides the bus and ends the open burst, as does a deselect
  task automatic t_sleep();
    m.cyc(2, 17'h00015, 1'b1, 1'b1, 1'b1, LANES_ALL, '0);
    m.sleep_on();
    #1;
    check_bit("dqOe", 1'b0, dqOe);
    m.wake();
    m.cyc(0, '0, 1'b0, 1'b1, 1'b1, LANES_ALL, '0);
    repeat (2) m.cyc(0, '0, 1'b1, 1'b1, 1'b1, LANES_ALL, '0);
    #1;
    check_bit("dqOe", 1'b0, dqOe);
    rd_burst(17'h00005, 1, 0, 2);
    // a strobe while deselected closes the burst, so a step reads nothing
    m.cyc(3, '0, 1'b1, 1'b1, 1'b1, LANES_ALL, '0);
    m.cyc(0, '0, 1'b0, 1'b1, 1'b1, LANES_ALL, '0);
    repeat (2) m.cyc(0, '0, 1'b1, 1'b1, 1'b1, LANES_ALL, '0);
    #1;
    check_bit("dqOe", 1'b0, dqOe);
  endtask

  // interleaved order, then output enable gating mid-burst
  task automatic t_interleave();
    do_reset(1'b1);
    inter = 1'b1;
    wr_burst(17'h00015, 3, 0, 1'b0, 1'b1, 4'hF);
    rd_burst(17'h00015, 5, 0, 1);
    m.set_oe(1'b1);
    #1;
    check_bit("dqOe", 1'b0, dqOe);
    m.set_oe(1'b0);
    #1;
    check_bit("dqOe", 1'b1, dqOe);
  endtask

  task automatic wrap_up();
    if (failures == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    do_reset(1'b0);
    t_linear();
    t_suspend();
    t_lanes();
    t_sleep();
    t_interleave();
    wrap_up();
  end

  // whole run is under a hundred clocks; this cuts a hang well past that
  initial begin
    repeat (4000) @(posedge clk);
    failures++;
    wrap_up();
  end
endmodule
